// ===== hdl/ulc_pkg.sv
package ulc_pkg;

   // Register byte addresses
   localparam logic [11:0] ADDR_LIST_CTRL  = 12'h000;
   localparam logic [11:0] ADDR_CMD_STATE  = 12'h004;
   localparam logic [11:0] ADDR_BULK_PTR   = 12'h008;
   localparam logic [11:0] ADDR_CTRL_PTR   = 12'h00c;
   localparam logic [11:0] ADDR_INT_STATUS = 12'h010;
   localparam logic [11:0] ADDR_INT_MASK   = 12'h014;

   // List control fields
   localparam int RATIO_LSB   = 0;
   localparam int PERIODIC_B  = 2;
   localparam int ISO_B       = 3;
   localparam int FSTATE_LSB  = 6;

   // Command and state fields
   localparam int SOFT_RST_B  = 0;
   localparam int CTRL_FILL_B = 1;
   localparam int BULK_FILL_B = 2;
   localparam int OWN_REQ_B   = 3;
   localparam int OVR_CNT_LSB = 16;

   // Interrupt status bits
   localparam int IRQ_OVERRUN_B  = 0;
   localparam int IRQ_RST_DONE_B = 1;
   localparam int IRQ_W          = 2;

   // Software reset sequence length
   localparam int          SOFT_RST_TIME_NS = 200;
   localparam int          CLK_PERIOD_NS    = 40;
   localparam logic [3:0]  SOFT_RST_CYCLES  =
      4'((SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Reset value and bus transfer type
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

   // Functional states
   typedef enum logic [1:0]
   {
      FS_USB_RESET   = 2'h0,
      FS_USB_RESUME  = 2'h1,
      FS_USB_OPER    = 2'h2,
      FS_USB_SUSPEND = 2'h3
   } ulc_fstate_type;

   // Scheduler-facing enables and control per bulk count, one bundle
   typedef struct packed
   {
      logic       periodic_run;
      logic       iso_run;
      logic [2:0] control_per_bulk;
   } ulc_sched_type;

endpackage : ulc_pkg

// ===== hdl/ulc_frame_gate.sv
`timescale 1ns/10ps
`default_nettype none

// Applies list enables at frame boundaries; sync clear drops them at once
module ulc_frame_gate
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic sync_clear_in,
   // Frame boundary and requested enables
   input  wire logic frame_start_in,
   input  wire logic periodic_req_in,
   input  wire logic iso_req_in,
   // Enables in force for this frame
   output logic      periodic_run_out,
   output logic      iso_run_out
);

   // Latch new enables only at the next frame start
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         periodic_run_out <= 1'b0;
         iso_run_out      <= 1'b0;
      end
      else if (sync_clear_in)
      begin
         periodic_run_out <= 1'b0;
         iso_run_out      <= 1'b0;
      end
      else if (frame_start_in)
      begin
         periodic_run_out <= periodic_req_in; // R2 R3
         iso_run_out      <= iso_req_in;      // R1
      end
   end

endmodule : ulc_frame_gate

`default_nettype wire

// ===== hdl/ulc_top.sv
// How it works
// R1: Isochronous enable takes effect at the next frame start.
// R2: Clearing periodic enable stops periodic lists from the next frame.
// R3: Setting periodic enable starts periodic lists in the next frame.
// R4: Ratio field bits 1-0 value N gives N+1 control per bulk.
// R5: Two-bit overrun count in bits 17-16 counts every overrun event.
// R6: Ownership request bit 3 is storable; it never raises an interrupt.
// R7: Software sets bulk-filled bit 2 after adding bulk descriptors.
// R8: Bulk start with zero current pointer needs bulk-filled set.
// R9: Hardware clears bulk-filled when it starts bulk processing.
// R10: Software sets control-filled bit 1 after adding control descriptors.
// R11: Control start with zero head pointer needs control-filled set.
// R12: Hardware clears control-filled when it starts control processing.
// R13: Writing 1 to bit 0 starts soft reset into suspend; 0 ignored.
// R14: Software polls reset bit until zero before other accesses.
// R15: Soft reset leaves root hub alone, no downstream USB reset.
// R16: State field bits 7-6; soft reset gives suspend, hard reset gives reset.
// R17: Reset bit clears itself when the soft reset sequence ends.
// R18: Overrun count wraps from three to zero.
`timescale 1ns/10ps
`default_nettype none

module ulc_top
   import ulc_pkg::*;
(
   // Clock and reset
   input  wire logic                 CLK_IN,
   input  wire logic                 RESETN_IN,
   // AHB-Lite slave
   input  wire logic                 HSEL_IN,
   input  wire logic [11:0]          HADDR_IN,
   input  wire logic [1:0]           HTRANS_IN,
   input  wire logic                 HWRITE_IN,
   input  wire logic [2:0]           HSIZE_IN,
   input  wire logic [31:0]          HWDATA_IN,
   input  wire logic                 HREADY_IN,
   output logic      [31:0]          HRDATA_OUT,
   output logic                      HREADYOUT_OUT,
   output logic                      HRESP_OUT,
   // List scheduler events
   input  wire logic                 FRAME_START_IN,
   input  wire logic                 OVERRUN_IN,
   input  wire logic                 CTRL_START_REQ_IN,
   input  wire logic                 BULK_START_REQ_IN,
   // Scheduler controls
   output ulc_pkg::ulc_sched_type    SCHED_OUT,
   output logic                      CTRL_START_OUT,
   output logic                      BULK_START_OUT,
   output logic                      SOFT_RESET_OUT,
   output logic      [1:0]           FSTATE_OUT,
   // Interrupt
   output logic                      IRQ_OUT
);

   // Register state
   logic [1:0]          ratio;
   logic                periodic_en;
   logic                iso_en;
   ulc_fstate_type      fstate;
   logic [1:0]          ovr_cnt;
   logic                own_req;
   logic                bulk_fill;
   logic                ctrl_fill;
   logic                soft_rst;
   logic [3:0]          rst_cnt;
   logic [31:0]         bulk_ptr;
   logic [31:0]         ctrl_ptr;
   logic [IRQ_W-1:0]    int_status;
   logic [IRQ_W-1:0]    int_mask;

   // Address phase capture
   logic                wr_pend;
   logic [11:0]         addr_q;

   // Ratio as a served count
   function automatic logic [2:0] ratio_count(input logic [1:0] r);
      ratio_count = {1'b0, r} + 3'h1;
   endfunction : ratio_count

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction : hit

   // Bus decode
   wire  addr_ok     = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ);
   wire  wr_list     = wr_pend && hit(addr_q, ADDR_LIST_CTRL);
   wire  wr_cmd      = wr_pend && hit(addr_q, ADDR_CMD_STATE);
   wire  wr_bptr     = wr_pend && hit(addr_q, ADDR_BULK_PTR);
   wire  wr_cptr     = wr_pend && hit(addr_q, ADDR_CTRL_PTR);
   wire  wr_mask     = wr_pend && hit(addr_q, ADDR_INT_MASK);
   wire  rd_status   = addr_ok && !HWRITE_IN && hit(HADDR_IN, ADDR_INT_STATUS);

   // List start arbitration with filled flags
   wire  start_ok    = !soft_rst;                         // No start, no flag use in soft reset
   wire  ctrl_work   = (ctrl_ptr != ZERO_WORD) || ctrl_fill;                        // R11
   wire  bulk_work   = (bulk_ptr != ZERO_WORD) || bulk_fill;                        // R8
   wire  ctrl_go     = CTRL_START_REQ_IN && ctrl_work && start_ok;                  // R11
   wire  bulk_go     = BULK_START_REQ_IN && bulk_work && start_ok;                  // R8
   wire  soft_start  = wr_cmd && HWDATA_IN[SOFT_RST_B] && !soft_rst;                // R13
   wire  soft_done   = soft_rst && (rst_cnt == 4'h1);
   wire  [1:0] ovr_inc = ovr_cnt + 2'h1;                                           // R18

   // Read data mux
   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = ZERO_WORD;
      unique case (HADDR_IN)
         ADDR_LIST_CTRL:
         begin
            rd_word[RATIO_LSB +: 2]  = ratio;
            rd_word[PERIODIC_B]      = periodic_en;
            rd_word[ISO_B]           = iso_en;
            rd_word[FSTATE_LSB +: 2] = fstate;                       // R16
         end
         ADDR_CMD_STATE:
         begin
            rd_word[SOFT_RST_B]       = soft_rst;
            rd_word[CTRL_FILL_B]      = ctrl_fill;
            rd_word[BULK_FILL_B]      = bulk_fill;
            rd_word[OWN_REQ_B]        = own_req;
            rd_word[OVR_CNT_LSB +: 2] = ovr_cnt;
         end
         ADDR_BULK_PTR:   rd_word = bulk_ptr;
         ADDR_CTRL_PTR:   rd_word = ctrl_ptr;
         ADDR_INT_STATUS: rd_word[IRQ_W-1:0] = int_status;
         ADDR_INT_MASK:   rd_word[IRQ_W-1:0] = int_mask;
         default:         rd_word = ZERO_WORD;
      endcase
   end

   // Bus phase tracking, zero wait state
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         wr_pend    <= 1'b0;
         addr_q     <= 12'h000;
         HRDATA_OUT <= ZERO_WORD;
      end
      else
      begin
         wr_pend <= addr_ok && HWRITE_IN;
         addr_q  <= HADDR_IN;
         if (addr_ok && !HWRITE_IN)
            HRDATA_OUT <= rd_word;
      end
   end

   // Fixed bus answer
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         HREADYOUT_OUT <= 1'b0;
         HRESP_OUT     <= 1'b0;
      end
      else
      begin
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT     <= 1'b0;
      end
   end

   // List control register
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ratio       <= 2'h0;
         periodic_en <= 1'b0;
         iso_en      <= 1'b0;
         fstate      <= FS_USB_RESET;                                // R16
      end
      else if (soft_start)
      begin
         ratio       <= 2'h0;
         periodic_en <= 1'b0;
         iso_en      <= 1'b0;
         fstate      <= FS_USB_SUSPEND;                              // R13 R16
      end
      else if (wr_list && !soft_rst)
      begin
         ratio       <= HWDATA_IN[RATIO_LSB +: 2];                   // R4
         periodic_en <= HWDATA_IN[PERIODIC_B];
         iso_en      <= HWDATA_IN[ISO_B];
         fstate      <= ulc_fstate_type'(HWDATA_IN[FSTATE_LSB +: 2]);
      end
   end

   // Command flags; hardware clears fill flags on start, software sets
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         own_req   <= 1'b0;
         bulk_fill <= 1'b0;
         ctrl_fill <= 1'b0;
      end
      else if (soft_start)
      begin
         own_req   <= 1'b0;
         bulk_fill <= 1'b0;
         ctrl_fill <= 1'b0;
      end
      else
      begin
         if (wr_cmd && HWDATA_IN[OWN_REQ_B])
            own_req <= 1'b1;                                         // R6
         if (wr_cmd && HWDATA_IN[BULK_FILL_B])
            bulk_fill <= 1'b1;                                       // R7
         else if (bulk_go)
            bulk_fill <= 1'b0;                                       // R9
         if (wr_cmd && HWDATA_IN[CTRL_FILL_B])
            ctrl_fill <= 1'b1;                                       // R10
         else if (ctrl_go)
            ctrl_fill <= 1'b0;                                       // R12
      end
   end

   // Overrun counter, counts regardless of pending interrupt
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         ovr_cnt <= 2'h0;
      else if (soft_start)
         ovr_cnt <= 2'h0;
      else if (OVERRUN_IN)
         ovr_cnt <= ovr_inc;                                         // R5 R18
   end

   // Soft reset sequencer; root hub is not touched
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         soft_rst <= 1'b0;
         rst_cnt  <= 4'h0;
      end
      else if (soft_start)
      begin
         soft_rst <= 1'b1;                                           // R13
         rst_cnt  <= SOFT_RST_CYCLES;
      end
      else if (soft_done)
      begin
         soft_rst <= 1'b0;                                           // R17
         rst_cnt  <= 4'h0;
      end
      else if (soft_rst)
         rst_cnt <= rst_cnt - 4'h1;
   end

   // Descriptor pointers
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         bulk_ptr <= ZERO_WORD;
         ctrl_ptr <= ZERO_WORD;
      end
      else if (soft_start)
      begin
         bulk_ptr <= ZERO_WORD;
         ctrl_ptr <= ZERO_WORD;
      end
      else
      begin
         if (wr_bptr && !soft_rst)
            bulk_ptr <= HWDATA_IN;
         if (wr_cptr && !soft_rst)
            ctrl_ptr <= HWDATA_IN;
      end
   end

   // Interrupt status: set wins over read clear; no ownership event
   logic [IRQ_W-1:0] int_set;
   assign int_set[IRQ_OVERRUN_B]  = OVERRUN_IN;
   assign int_set[IRQ_RST_DONE_B] = soft_done;
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         int_status <= '0;
         int_mask   <= '0;
      end
      else
      begin
         int_status <= (rd_status ? '0 : int_status) | int_set;      // R6
         if (wr_mask)
            int_mask <= HWDATA_IN[IRQ_W-1:0];
      end
   end

   // Frame-aligned enables
   logic periodic_run;
   logic iso_run;
   ulc_frame_gate u_frame_gate
   (
      .clk_in           (CLK_IN),
      .resetn_in        (RESETN_IN),
      .sync_clear_in    (soft_rst),
      .frame_start_in   (FRAME_START_IN),
      .periodic_req_in  (periodic_en),
      .iso_req_in       (iso_en),
      .periodic_run_out (periodic_run),
      .iso_run_out      (iso_run)
   );

   // Registered outputs to scheduler
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         SCHED_OUT      <= '0;
         CTRL_START_OUT <= 1'b0;
         BULK_START_OUT <= 1'b0;
         SOFT_RESET_OUT <= 1'b0;
         FSTATE_OUT     <= FS_USB_RESET;
         IRQ_OUT        <= 1'b0;
      end
      else
      begin
         SCHED_OUT.periodic_run     <= periodic_run;                 // R2 R3
         SCHED_OUT.iso_run          <= iso_run;                      // R1
         SCHED_OUT.control_per_bulk <= ratio_count(ratio);           // R4
         CTRL_START_OUT <= ctrl_go && !soft_rst;                     // R11
         BULK_START_OUT <= bulk_go && !soft_rst;                     // R8
         SOFT_RESET_OUT <= soft_rst;                                 // R15
         FSTATE_OUT     <= fstate;
         IRQ_OUT        <= |(int_status & int_mask);
      end
   end

endmodule : ulc_top

`default_nettype wire

// ===== test/ulc_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Port-level checks of the list control block
module ulc_chk
   import ulc_pkg::*;
(
   // Clock and reset
   input wire logic                  CLK_IN,
   input wire logic                  RESETN_IN,
   // Bus and scheduler signals
   input wire logic                  HRESP_OUT,
   input wire logic                  HREADYOUT_OUT,
   input wire logic                  FRAME_START_IN,
   input wire logic                  CTRL_START_REQ_IN,
   input wire logic                  BULK_START_REQ_IN,
   input wire ulc_pkg::ulc_sched_type SCHED_OUT,
   input wire logic                  CTRL_START_OUT,
   input wire logic                  BULK_START_OUT,
   input wire logic                  SOFT_RESET_OUT,
   input wire logic      [1:0]       FSTATE_OUT
);
   // One clock domain
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   // Bus answers
   a_resp_okay: assert property (HRESP_OUT == 1'b0)
      else $error("response not okay");
   a_ready_high: assert property ($past(RESETN_IN) |-> HREADYOUT_OUT)
      else $error("wait state inserted");
   // Grants follow a request by one cycle
   a_ctrl_grant: assert property (CTRL_START_OUT |-> $past(CTRL_START_REQ_IN))
      else $error("control start without request");
   a_bulk_grant: assert property (BULK_START_OUT |-> $past(BULK_START_REQ_IN))
      else $error("bulk start without request");
   // Enables move only after a frame start or soft reset
   a_run_frame: assert property ($changed({SCHED_OUT.periodic_run, SCHED_OUT.iso_run})
      |-> $past(FRAME_START_IN) || $past(FRAME_START_IN, 2) || $past(FRAME_START_IN, 3)
      || SOFT_RESET_OUT || $past(SOFT_RESET_OUT) || $past(SOFT_RESET_OUT, 2))
      else $error("enable changed inside a frame");
   a_ratio_range: assert property (SCHED_OUT.control_per_bulk <= 3'h4)
      else $error("ratio out of range");
   // Soft reset length, end state and hard reset state
   a_soft_len: assert property ($rose(SOFT_RESET_OUT)
      |-> SOFT_RESET_OUT [*5] ##1 !SOFT_RESET_OUT)
      else $error("soft reset length wrong");
   a_soft_state: assert property ($fell(SOFT_RESET_OUT) |-> FSTATE_OUT == FS_USB_SUSPEND)
      else $error("soft reset did not suspend");
   a_hard_state: assert property (!$past(RESETN_IN) |-> FSTATE_OUT == FS_USB_RESET)
      else $error("hard reset state wrong");
endmodule : ulc_chk

bind ulc_top ulc_chk u_ulc_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .HRESP_OUT(HRESP_OUT),
   .HREADYOUT_OUT(HREADYOUT_OUT), .FRAME_START_IN(FRAME_START_IN),
   .CTRL_START_REQ_IN(CTRL_START_REQ_IN), .BULK_START_REQ_IN(BULK_START_REQ_IN),
   .SCHED_OUT(SCHED_OUT), .CTRL_START_OUT(CTRL_START_OUT), .BULK_START_OUT(BULK_START_OUT),
   .SOFT_RESET_OUT(SOFT_RESET_OUT), .FSTATE_OUT(FSTATE_OUT));

`default_nettype wire

// ===== test/test_usb_host_list_command_control.sv
`timescale 1ns/10ps
`default_nettype none

module test_usb_host_list_command_control;
   import ulc_pkg::*;

   // Bench signals
   logic          clk, rstn, hsel, hwrite, frame, ovr, creq, breq;
   logic          hreadyout, hresp, cst, bst, srst, irq;
   logic [11:0]   haddr;
   logic [1:0]    htrans, fst;
   logic [31:0]   hwdata, hrdata, r;
   ulc_sched_type sched;
   int            n_mismatch, total_checks, gn, cyc, i, k, sr_seen;

   ulc_top u_ulc_top (.CLK_IN(clk), .RESETN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
      .HRESP_OUT(hresp), .FRAME_START_IN(frame), .OVERRUN_IN(ovr),
      .CTRL_START_REQ_IN(creq), .BULK_START_REQ_IN(breq), .SCHED_OUT(sched),
      .CTRL_START_OUT(cst), .BULK_START_OUT(bst), .SOFT_RESET_OUT(srst),
      .FSTATE_OUT(fst), .IRQ_OUT(irq));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Grant count, soft reset seen, timeout
   always @(posedge clk)
   begin
      cyc++;
      gn += int'(cst === 1'b1) + int'(bst === 1'b1);
      if (srst === 1'b1) sr_seen = 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   // Verdict and end of run
   task summarize();
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // Value compare
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // One AHB-Lite single word transfer, result in r
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0000_0000);
      chk(n, e, r);
   endtask : rd

   // Start request pulse, control when s is 0
   task req(input int s);
      @(posedge clk);
      creq <= (s == 0);
      breq <= (s == 1);
      @(posedge clk);
      creq <= 1'b0;
      breq <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : req

   // Frame boundary pulse
   task fr();
      @(posedge clk);
      frame <= 1'b1;
      @(posedge clk);
      frame <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : fr

   // Main sequence
   initial
   begin
      {rstn, hwrite, frame, ovr, creq, breq, haddr, htrans, hwdata} = '0;
      hsel = 1'b1;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_CMD_STATE, 32'h0000_0000, "cmd reset");
      chk("fstate reset", 32'h0000_0000, {30'h0, fst});
      wr(12'h020, 32'hffff_ffff);
      rd(12'h020, 32'h0000_0000, "unmapped");
      // Enables wait for the next frame
      wr(ADDR_LIST_CTRL, 32'h0000_000f);
      rd(ADDR_LIST_CTRL, 32'h0000_000f, "list ctrl");
      chk("run early", 32'h0, {30'h0, sched.periodic_run, sched.iso_run});
      fr();
      chk("sched on", 32'h0000_001c, {27'h0, sched});
      wr(ADDR_LIST_CTRL, 32'h0000_0003);
      chk("run held", 32'h3, {30'h0, sched.periodic_run, sched.iso_run});
      fr();
      chk("sched off", 32'h0000_0004, {27'h0, sched});
      for (i = 0; i < 4; i++)
      begin
         wr(ADDR_LIST_CTRL, 32'(i));
         fr();
         chk("ratio", 32'(i + 1), {29'h0, sched.control_per_bulk});
      end
      // Overrun count, interrupt raise, clear and mask
      wr(ADDR_INT_MASK, 32'h0000_0001);
      @(posedge clk);
      ovr <= 1'b1;
      repeat (5) @(posedge clk);
      ovr <= 1'b0;
      rd(ADDR_CMD_STATE, 32'h0001_0000, "overrun count");
      chk("irq on", 32'h1, {31'h0, irq});
      rd(ADDR_INT_STATUS, 32'h0000_0001, "int status");
      repeat (2) @(posedge clk);
      chk("irq off", 32'h0, {31'h0, irq});
      wr(ADDR_INT_MASK, 32'h0000_0000);
      @(posedge clk);
      ovr <= 1'b1;
      @(posedge clk);
      ovr <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(ADDR_INT_STATUS, 32'h0000_0001, "status masked");
      // Ownership request raises no interrupt
      wr(ADDR_INT_MASK, 32'h0000_0003);
      wr(ADDR_CMD_STATE, 32'h0000_0008);
      rd(ADDR_CMD_STATE, 32'h0002_0008, "own req");
      chk("irq own", 32'h0, {31'h0, irq});
      // List starts: control then bulk
      for (i = 0; i < 2; i++)
      begin
         gn = 0;
         req(i);
         chk("no start", 32'h0, 32'(gn));
         wr(ADDR_CMD_STATE, 32'h0000_0002 << i);
         rd(ADDR_CMD_STATE, 32'h0002_0008 | (32'h0000_0002 << i), "filled");
         req(i);
         chk("start", 32'h1, 32'(gn));
         rd(ADDR_CMD_STATE, 32'h0002_0008, "filled cleared");
         wr(i == 0 ? ADDR_CTRL_PTR : ADDR_BULK_PTR, 32'h0000_0100);
         req(i);
         chk("ptr start", 32'h2, 32'(gn));
      end
      // Soft reset
      wr(ADDR_CMD_STATE, 32'h0000_0000);
      rd(ADDR_CMD_STATE, 32'h0002_0008, "write zero");
      wr(ADDR_CMD_STATE, 32'h0000_0001);
      r = 32'h0000_0001;
      k = 0;
      while (r[0] === 1'b1 && k < 20)
      begin
         xfer(1'b0, ADDR_CMD_STATE, 32'h0000_0000);
         k++;
      end
      chk("reset bit", 32'h0000_0000, r);
      chk("reset seen", 32'h1, 32'(sr_seen));
      chk("fstate susp", 32'h3, {30'h0, fst});
      rd(ADDR_LIST_CTRL, 32'h0000_00c0, "list after");
      chk("irq done", 32'h1, {31'h0, irq});
      rd(ADDR_INT_STATUS, 32'h0000_0002, "reset done");
      wr(ADDR_LIST_CTRL, 32'h0000_0080);
      rd(ADDR_LIST_CTRL, 32'h0000_0080, "list oper");
      chk("fstate oper", 32'h2, {30'h0, fst});
      summarize();
   end
endmodule : test_usb_host_list_command_control

`default_nettype wire
